// *** inc/scis_pkg.sv ***
// Shared constants, types and helpers of the star coupler interrupt and status block.
package scis_pkg;
   // Clock and timing.
   localparam int CLK_MHZ = 20;
   localparam int CLK_NS = 50;
   localparam int IRQ_GAP_NS = 100;
   localparam int IRQ_GAP_CYC = (IRQ_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int IO_UV_TO_US = 1000;
   localparam int IO_UV_TO_CYC = IO_UV_TO_US * CLK_MHZ;

   // Serial frame layout.
   localparam int FRAME_BITS = 16;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam logic [3:0] SEL_IRQ = 4'h1;
   localparam logic [3:0] SEL_GEN = 4'h2;
   localparam logic [3:0] SEL_MODE = 4'h8;

   // Interrupt status word.
   localparam int IRQ_POWER_ON_FLAG = 11;
   localparam int IRQ_WAKE = 10;
   localparam int IRQ_BR1 = 9;
   localparam int IRQ_BR2 = 8;
   localparam int IRQ_UV = 5;
   localparam int IRQ_CLAMP = 4;
   localparam int IRQ_SPI = 3;
   localparam int IRQ_HC = 2;
   localparam int IRQ_TEMP = 1;
   localparam logic [11:0] IRQ_RST = 12'h800;

   // General status word.
   localparam int GEN_LWAKE = 11;
   localparam int GEN_SWAKE = 10;
   localparam int GEN_GUARD = 9;
   localparam int GEN_BAT = 8;
   localparam int GEN_VCC = 7;
   localparam int GEN_VIO = 6;
   localparam int GEN_TWARN = 5;
   localparam int GEN_THIGH = 4;
   localparam int GEN_CLTRX = 3;
   localparam int GEN_CLTXEN = 2;
   localparam int GEN_COLL = 1;
   localparam int PAR_BIT = 0;
   localparam logic [8:2] LAT_RST = 7'h00;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_STANDBY = 2'h1,
      MODE_SLEEP = 2'h2,
      MODE_OTHER = 2'h3
   } scis_mode_e;

   typedef enum logic {
      FR_IDLE = 1'b0,
      FR_BUSY = 1'b1
   } scis_fr_e;

   // Parity bit that makes the whole 12-bit word odd.
   function automatic logic odd_par(input logic [11:1] d);
      return ~(^d);
   endfunction : odd_par
endpackage : scis_pkg

// *** inc/scis_frame_if.sv ***
// Hand-off between the serial frame unit and the status core.
`timescale 1ns/1ns
`default_nettype none
interface scis_frame_if;
   logic start;
   logic done;
   logic ok;
   logic [15:0] rx;
   logic [15:0] tx;
   modport fr (output start, output done, output ok, output rx, input tx);
   modport core (input start, input done, input ok, input rx, output tx);
endinterface : scis_frame_if
`default_nettype wire

// *** rtl/scis_spi_frame.sv ***
// Serial frame unit: samples the host pins, shifts one word in and out per frame.
`timescale 1ns/1ns
`default_nettype none
module scis_spi_frame (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Serial pins
   input wire logic chip_select_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // Frame hand-off
   scis_frame_if.fr fr
);
   import scis_pkg::*;

   logic [2:0] cs_s_reg;
   logic [2:0] ck_s_reg;
   logic [2:0] di_s_reg;
   logic cs_f_reg;
   logic ck_f_reg;
   logic di_f_reg;
   scis_fr_e st_reg;
   logic [15:0] rx_reg;
   logic [15:0] tx_reg;
   logic [4:0] cnt_reg;
   logic sdo_reg;
   logic oe_reg;
   logic start_reg;
   logic done_reg;
   logic ok_reg;
   logic cs_upd;
   logic ck_upd;

   // A level counts only once the second and third stage agree.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cs_s_reg <= 3'h7;
         ck_s_reg <= 3'h0;
         di_s_reg <= 3'h0;
         cs_f_reg <= 1'b1;
         ck_f_reg <= 1'b0;
         di_f_reg <= 1'b0;
      end else begin
         cs_s_reg <= {cs_s_reg[1:0], chip_select_n_i};
         ck_s_reg <= {ck_s_reg[1:0], sclk_i};
         di_s_reg <= {di_s_reg[1:0], sdi_i};
         if (cs_s_reg[1] == cs_s_reg[2]) cs_f_reg <= cs_s_reg[2];
         if (ck_s_reg[1] == ck_s_reg[2]) ck_f_reg <= ck_s_reg[2];
         if (di_s_reg[1] == di_s_reg[2]) di_f_reg <= di_s_reg[2];
      end
   end

   assign cs_upd = (cs_s_reg[1] == cs_s_reg[2]) && (cs_s_reg[2] != cs_f_reg);
   assign ck_upd = (ck_s_reg[1] == ck_s_reg[2]) && (ck_s_reg[2] != ck_f_reg);

   // Data is taken on the rising serial edge and moved out on the falling one.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= FR_IDLE;
         rx_reg <= 16'h0000;
         tx_reg <= 16'h0000;
         cnt_reg <= 5'h00;
         sdo_reg <= 1'b0;
         oe_reg <= 1'b0;
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         ok_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         case (st_reg)
            FR_IDLE: begin
               if (cs_upd && !cs_s_reg[2]) begin
                  st_reg <= FR_BUSY;
                  tx_reg <= fr.tx;
                  sdo_reg <= fr.tx[15];
                  oe_reg <= 1'b1;
                  cnt_reg <= 5'h00;
                  start_reg <= 1'b1;
               end
            end
            FR_BUSY: begin
               if (cs_upd && cs_s_reg[2]) begin
                  st_reg <= FR_IDLE;
                  oe_reg <= 1'b0;
                  done_reg <= 1'b1;
                  ok_reg <= (cnt_reg == 5'(FRAME_BITS)); // see RL25 see RL10
               end else if (start_reg) begin
                  // Reload in the cycle the core freezes its copy, so the reply always equals what a read clears.
                  tx_reg <= fr.tx;
                  sdo_reg <= fr.tx[15];
               end else if (ck_upd && ck_s_reg[2]) begin
                  rx_reg <= {rx_reg[14:0], di_f_reg};
                  if (cnt_reg != 5'h1f) cnt_reg <= cnt_reg + 5'h01; // see RL25
               end else if (ck_upd && !ck_s_reg[2]) begin
                  tx_reg <= {tx_reg[14:0], 1'b0};
                  sdo_reg <= tx_reg[14];
               end
            end
            default: st_reg <= FR_IDLE;
         endcase
      end
   end

   assign sdo_o = sdo_reg;
   assign sdo_oe_o = oe_reg;
   assign fr.start = start_reg;
   assign fr.done = done_reg;
   assign fr.ok = ok_reg;
   assign fr.rx = rx_reg;
endmodule : scis_spi_frame
`default_nettype wire

// *** rtl/scis_top.sv ***
// Interrupt and general status core of the star coupler with its serial host port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// RL1: Power-on flag set leaving reset, read-cleared.
// RL2: Wake flag from branch, link or pin.
// RL3: Branch event flag on wake, error, clamp.
// RL4: Condition flags clear once source gone, read.
// RL5: Branch event clear re-pulses interrupt, except wake.
// RL6: Undervoltage flag from any supply bit.
// RL7: Undervoltage flag clear re-pulses interrupt pin.
// RL8: Clamp flag from clamps or link collision.
// RL9: Clamp flag clear re-pulses interrupt pin.
// RL10: Frame not sixteen clocks sets serial error.
// RL11: Illegal mode request sets command error.
// RL12: Overtemperature flag from warning or high.
// RL13: Overtemperature flag clear re-pulses interrupt pin.
// RL14: Local wake bit: set, read/mode-exit clear.
// RL15: Link wake bit: same as local wake.
// RL16: Guardian bit mirrors guardian pin level.
// RL17: Latched supply bits hold until status read.
// RL18: Unlatched supply bits follow detectors live.
// RL19: I/O undervoltage blocks inputs and commands.
// RL20: Long I/O undervoltage enters autonomous mode.
// RL21: General status bit order eleven down.
// RL22: Bit zero is odd parity.
// RL23: Any new interrupt bit gives falling edge.
// RL24: Interrupt status bit order as listed.
// RL25: Count clocks under select, judge at rise.
module scis_top #(
   parameter int IO_UV_TIMEOUT_CYC = scis_pkg::IO_UV_TO_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Serial host port
   input wire logic chip_select_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // Pins
   input wire logic local_wake_pin_i,
   input wire logic bus_guardian_enable_pin_i,
   output logic irq_n_o,
   // Detectors and branch status, same clock
   input wire logic star_link_wake_i,
   input wire logic star_link_collision_i,
   input wire logic star_link_clamp_i,
   input wire logic tx_enable_clamp_i,
   input wire logic battery_low_i,
   input wire logic core_supply_low_i,
   input wire logic io_supply_low_i,
   input wire logic temp_warn_i,
   input wire logic temp_high_i,
   input wire logic [1:0] branch_wake_flag_i,
   input wire logic [1:0] branch_tx_error_flag_i,
   input wire logic [1:0] branch_clamp_flag_i,
   // Mode logic
   input wire scis_pkg::scis_mode_e mode_i,
   input wire logic status_latch_en_i,
   input wire logic host_cmd_error_i,
   output logic mode_req_valid_o,
   output logic [11:0] mode_req_o,
   output logic io_inputs_blocked_o,
   output logic autonomous_mode_flag_o
);
   import scis_pkg::*;

   scis_frame_if frame_bus ();

   scis_spi_frame u_frame (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .chip_select_n_i(chip_select_n_i),
      .sclk_i(sclk_i),
      .sdi_i(sdi_i),
      .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o),
      .fr(frame_bus)
   );

   logic [2:0] lw_s_reg;
   logic [2:0] bg_s_reg;
   logic lw_f_reg;
   logic guardian_pin_level_reg;
   logic [3:0] sel_reg;
   logic [3:0] snap_sel_reg;
   logic [11:0] snap_reg;
   scis_mode_e mode_prev_reg;
   logic local_wake_flag_reg;
   logic star_link_wake_flag_reg;
   logic star_link_collision_flag_reg;
   logic [8:2] lat_reg;
   logic [11:1] irq_reg;
   logic [1:0] brw_prev_reg;
   logic [1:0] br_cause_reg;
   logic pend_reg;
   logic [1:0] gap_reg;
   logic irq_n_reg;
   logic mode_req_valid_reg;
   logic [11:0] mode_req_reg;
   logic io_blk_reg;
   logic [31:0] uv_cnt_reg;
   logic apm_reg;

   logic io_uv;
   logic local_wake_evt;
   logic frm_done;
   logic frm_ok;
   logic irq_rd_ok;
   logic gen_rd_ok;
   logic leave_normal;
   logic [1:0] br_src;
   logic uv_src;
   logic clamp_src;
   logic temp_src;
   logic set_wake;
   logic [11:1] irq_set;
   logic [11:1] irq_src;
   logic [11:1] irq_clr;
   logic [11:1] res_mask;
   logic new_set;
   logic resolve;
   logic [11:0] irq_word;
   logic [11:0] gen_word;

   // Pins from outside the clock domain pass three stages.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lw_s_reg <= 3'h0;
         bg_s_reg <= 3'h0;
         lw_f_reg <= 1'b0;
         guardian_pin_level_reg <= 1'b0;
      end else begin
         lw_s_reg <= {lw_s_reg[1:0], local_wake_pin_i};
         bg_s_reg <= {bg_s_reg[1:0], bus_guardian_enable_pin_i};
         if (lw_s_reg[1] == lw_s_reg[2]) lw_f_reg <= lw_s_reg[2];
         if (bg_s_reg[1] == bg_s_reg[2]) guardian_pin_level_reg <= bg_s_reg[2]; // see RL16
      end
   end

   assign io_uv = io_supply_low_i;
   assign local_wake_evt = (lw_s_reg[1] == lw_s_reg[2]) && lw_s_reg[2] && !lw_f_reg && !io_uv; // see RL19
   assign frm_done = frame_bus.done && !io_uv; // see RL19
   assign frm_ok = frm_done && frame_bus.ok;
   assign irq_rd_ok = frm_ok && (snap_sel_reg == SEL_IRQ);
   assign gen_rd_ok = frm_ok && (snap_sel_reg == SEL_GEN);
   assign leave_normal = (mode_prev_reg == MODE_NORMAL) && ((mode_i == MODE_STANDBY) || (mode_i == MODE_SLEEP));

   // A frame returns the word picked by the last good frame; the picked word is frozen at select fall.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_reg <= SEL_IRQ;
         snap_sel_reg <= SEL_IRQ;
         snap_reg <= 12'h000;
         mode_prev_reg <= MODE_OTHER;
         mode_req_valid_reg <= 1'b0;
         mode_req_reg <= 12'h000;
      end else begin
         mode_prev_reg <= mode_i;
         mode_req_valid_reg <= 1'b0;
         if (frame_bus.start) begin
            snap_sel_reg <= sel_reg;
            snap_reg <= frame_bus.tx[11:0];
         end
         if (frm_ok) begin
            case (frame_bus.rx[ADDR_MSB:ADDR_LSB])
               SEL_IRQ, SEL_GEN: sel_reg <= frame_bus.rx[ADDR_MSB:ADDR_LSB];
               SEL_MODE: begin
                  mode_req_valid_reg <= 1'b1; // see RL19
                  mode_req_reg <= frame_bus.rx[11:0];
               end
               default: sel_reg <= sel_reg;
            endcase
         end
      end
   end

   // General status flags; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         local_wake_flag_reg <= 1'b0;
         star_link_wake_flag_reg <= 1'b0;
         star_link_collision_flag_reg <= 1'b0;
         lat_reg <= LAT_RST;
      end else begin
         if (local_wake_evt) local_wake_flag_reg <= 1'b1; // see RL14
         else if ((gen_rd_ok && snap_reg[GEN_LWAKE]) || leave_normal) local_wake_flag_reg <= 1'b0; // see RL14
         if (star_link_wake_i) star_link_wake_flag_reg <= 1'b1; // see RL15
         else if ((gen_rd_ok && snap_reg[GEN_SWAKE]) || leave_normal) star_link_wake_flag_reg <= 1'b0; // see RL15
         if (star_link_collision_i) star_link_collision_flag_reg <= 1'b1;
         else if (gen_rd_ok && snap_reg[GEN_COLL]) star_link_collision_flag_reg <= 1'b0;
         if (status_latch_en_i) begin
            lat_reg <= (lat_reg & ~(gen_rd_ok ? snap_reg[8:2] : 7'h00)) | {battery_low_i, core_supply_low_i,
               io_supply_low_i, temp_warn_i, temp_high_i, star_link_clamp_i, tx_enable_clamp_i}; // see RL17
         end else begin
            lat_reg <= {battery_low_i, core_supply_low_i, io_supply_low_i, temp_warn_i, temp_high_i,
               star_link_clamp_i, tx_enable_clamp_i}; // see RL18
         end
      end
   end

   assign br_src = branch_wake_flag_i | branch_tx_error_flag_i | branch_clamp_flag_i; // see RL3
   assign uv_src = lat_reg[GEN_BAT] | lat_reg[GEN_VCC] | lat_reg[GEN_VIO]; // see RL6
   assign clamp_src = lat_reg[GEN_CLTRX] | lat_reg[GEN_CLTXEN] | star_link_collision_flag_reg
      | (|branch_clamp_flag_i); // see RL8
   assign temp_src = lat_reg[GEN_TWARN] | lat_reg[GEN_THIGH]; // see RL12
   assign set_wake = local_wake_evt | star_link_wake_i | (|(branch_wake_flag_i & ~brw_prev_reg)); // see RL2

   always_comb begin
      irq_set = '0;
      irq_src = '0;
      irq_set[IRQ_WAKE] = set_wake;
      irq_set[IRQ_BR1] = br_src[0];
      irq_set[IRQ_BR2] = br_src[1];
      irq_set[IRQ_UV] = uv_src;
      irq_set[IRQ_CLAMP] = clamp_src;
      irq_set[IRQ_SPI] = frm_done && !frame_bus.ok; // see RL10
      irq_set[IRQ_HC] = host_cmd_error_i; // see RL11
      irq_set[IRQ_TEMP] = temp_src;
      irq_src[IRQ_BR1] = br_src[0];
      irq_src[IRQ_BR2] = br_src[1];
      irq_src[IRQ_UV] = uv_src;
      irq_src[IRQ_CLAMP] = clamp_src;
      irq_src[IRQ_TEMP] = temp_src;
      irq_clr = irq_rd_ok ? (snap_reg[11:1] & ~irq_src) : '0; // see RL4 see RL1
      res_mask = '0;
      res_mask[IRQ_UV] = 1'b1;
      res_mask[IRQ_CLAMP] = 1'b1;
      res_mask[IRQ_TEMP] = 1'b1;
      res_mask[IRQ_BR1] = br_cause_reg[0];
      res_mask[IRQ_BR2] = br_cause_reg[1];
   end

   assign new_set = |(irq_set & ~irq_reg); // see RL23
   assign resolve = |(irq_clr & irq_reg & res_mask); // see RL5 see RL7 see RL9 see RL13

   // Interrupt flags; power-on is the reset value, so it shows as soon as rstn_i lifts.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_reg <= IRQ_RST[11:1]; // see RL1
         brw_prev_reg <= 2'h0;
         br_cause_reg <= 2'h0;
      end else begin
         irq_reg <= (irq_reg & ~irq_clr) | irq_set;
         brw_prev_reg <= branch_wake_flag_i;
         // A branch flag raised only by wake-up does not announce its clearing.
         br_cause_reg[0] <= (irq_reg[IRQ_BR1] && !irq_clr[IRQ_BR1] && br_cause_reg[0])
            || branch_tx_error_flag_i[0] || branch_clamp_flag_i[0]; // see RL5
         br_cause_reg[1] <= (irq_reg[IRQ_BR2] && !irq_clr[IRQ_BR2] && br_cause_reg[1])
            || branch_tx_error_flag_i[1] || branch_clamp_flag_i[1]; // see RL5
      end
   end

   // The pin is lifted for a short gap so that each announcement is a fresh falling edge.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_reg <= 1'b0;
         gap_reg <= 2'h0;
         irq_n_reg <= 1'b1;
      end else begin
         if (resolve) pend_reg <= 1'b1;
         else if (irq_rd_ok) pend_reg <= 1'b0;
         if (new_set || resolve) begin
            gap_reg <= 2'(IRQ_GAP_CYC); // see RL23
            irq_n_reg <= 1'b1;
         end else if (gap_reg != 2'h0) begin
            gap_reg <= gap_reg - 2'h1;
            irq_n_reg <= 1'b1;
         end else begin
            irq_n_reg <= ~((|irq_reg) | pend_reg);
         end
      end
   end

   // Autonomous control once the I/O supply stays low past the timeout.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         uv_cnt_reg <= 32'h0;
         apm_reg <= 1'b0;
         io_blk_reg <= 1'b0;
      end else begin
         io_blk_reg <= io_uv; // see RL19
         if (!io_uv) uv_cnt_reg <= 32'h0;
         else if (uv_cnt_reg < 32'(IO_UV_TIMEOUT_CYC)) uv_cnt_reg <= uv_cnt_reg + 32'h1;
         if (uv_cnt_reg >= 32'(IO_UV_TIMEOUT_CYC)) apm_reg <= 1'b1; // see RL20
      end
   end

   assign irq_word = {irq_reg[11:1], odd_par(irq_reg[11:1])}; // see RL24 see RL22
   assign gen_word = {local_wake_flag_reg, star_link_wake_flag_reg, guardian_pin_level_reg, lat_reg,
      star_link_collision_flag_reg, 1'b0};
   assign frame_bus.tx = {sel_reg, (sel_reg == SEL_GEN)
      ? {gen_word[11:1], odd_par(gen_word[11:1])} : irq_word}; // see RL21 see RL22

   assign irq_n_o = irq_n_reg;
   assign mode_req_valid_o = mode_req_valid_reg;
   assign mode_req_o = mode_req_reg;
   assign io_inputs_blocked_o = io_blk_reg;
   assign autonomous_mode_flag_o = apm_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   power_on_flag_clear_a: assert property (irq_rd_ok && snap_reg[IRQ_POWER_ON_FLAG] |=> !irq_reg[IRQ_POWER_ON_FLAG]) // see RL1
      else $error("power-on flag not cleared by read");
   wake_set_a: assert property (star_link_wake_i |=> irq_reg[IRQ_WAKE] && star_link_wake_flag_reg) // see RL2
      else $error("wake flag not set");
   branch_set_a: assert property (br_src[0] |=> irq_reg[IRQ_BR1]) // see RL3
      else $error("branch event flag not set");
   cond_hold_a: assert property (uv_src && irq_reg[IRQ_UV] |=> irq_reg[IRQ_UV]) // see RL4
      else $error("undervoltage flag cleared while source active");
   resolve_edge_a: assert property (resolve |-> ##[1:5] $fell(irq_n_reg)) // see RL7
      else $error("no falling edge after resolved condition");
   spi_err_a: assert property (frm_done && !frame_bus.ok |=> irq_reg[IRQ_SPI]) // see RL10
      else $error("serial error flag not set");
   new_irq_edge_a: assert property (new_set |=> irq_n_reg ##[1:4] $fell(irq_n_reg)) // see RL23
      else $error("no fresh falling edge for new interrupt");
   parity_ok_a: assert property (^frame_bus.tx[11:0]) // see RL22
      else $error("status word parity not odd");
   latch_hold_a: assert property (status_latch_en_i && lat_reg[GEN_BAT] && !gen_rd_ok |=> lat_reg[GEN_BAT]) // see RL17
      else $error("latched battery bit dropped before read");
   live_follow_a: assert property (!status_latch_en_i |=> lat_reg[GEN_VCC] == $past(core_supply_low_i)) // see RL18
      else $error("unlatched supply bit not live");
   io_block_a: assert property (io_uv |=> !mode_req_valid_reg) // see RL19
      else $error("host command accepted under I/O undervoltage");
   apm_set_a: assert property (io_uv && uv_cnt_reg >= 32'(IO_UV_TIMEOUT_CYC) |=> apm_reg) // see RL20
      else $error("autonomous mode not entered after timeout");

   irq_read_c: cover property (irq_rd_ok && snap_reg[IRQ_POWER_ON_FLAG]);
   spi_error_c: cover property (frm_done && !frame_bus.ok);
   resolve_c: cover property (resolve ##[1:5] $fell(irq_n_reg));
   apm_entry_c: cover property ($rose(apm_reg));
endmodule : scis_top
`default_nettype wire

// *** tb/scis_host_model.sv ***
// Host-side serial master model for the star coupler status port.
`timescale 1ns/1ns
`default_nettype none
module scis_host_model (
   // Serial pins
   output logic chip_select_n_o,
   output logic sclk_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   initial begin
      chip_select_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // The clock stands low between frames, and the data line is inverted once released.
   // Reply bits are taken late in the high phase, since the device shifts a few clocks after each fall.
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      #13 chip_select_n_o = 1'b0;
      #400;
      for (int k = 0; k < n; k++) begin
         sdi_o = w[15 - (k % 16)];
         #200 sclk_o = 1'b1;
         #190 r = {r[14:0], sdo_oe_i ? sdo_i : ~sdo_i};
         #10 sclk_o = 1'b0;
      end
      #400 chip_select_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #400;
   endtask : xfer
endmodule : scis_host_model
`default_nettype wire

// *** tb/scis_top_tb_top.sv ***
// Self-checking bench of the star coupler interrupt and status block.
`timescale 1ns/1ns
`default_nettype none
module scis_top_tb_top;
   import scis_pkg::*;
   localparam int TO_CYC = 50;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [14:0] src = '0;
   logic coll = 1'b0, guard = 1'b0, latch = 1'b0, vio = 1'b0;
   logic cs_n, sclk, sdi, sdo, soe, irq_n, mval, blocked, auton;
   logic [11:0] mreq;
   logic [15:0] rd;
   scis_mode_e mode = MODE_NORMAL;
   int miscompares = 0, checked = 0, nval = 0, seed = 32'h5d213738;

   always #25 clk = ~clk;
   always @(posedge clk) if (mval) nval <= nval + 1;

   scis_top #(.IO_UV_TIMEOUT_CYC(TO_CYC)) DUT (.clk_i(clk), .rstn_i(rstn), .chip_select_n_i(cs_n),
      .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(soe), .local_wake_pin_i(src[0]),
      .bus_guardian_enable_pin_i(guard), .irq_n_o(irq_n), .star_link_wake_i(src[1]),
      .star_link_collision_i(coll), .star_link_clamp_i(src[2]), .tx_enable_clamp_i(src[3]),
      .battery_low_i(src[4]), .core_supply_low_i(src[5]), .io_supply_low_i(vio), .temp_warn_i(src[6]),
      .temp_high_i(src[7]), .branch_wake_flag_i(src[9:8]), .branch_tx_error_flag_i(src[11:10]),
      .branch_clamp_flag_i(src[13:12]), .mode_i(mode), .status_latch_en_i(latch),
      .host_cmd_error_i(src[14]), .mode_req_valid_o(mval), .mode_req_o(mreq),
      .io_inputs_blocked_o(blocked), .autonomous_mode_flag_o(auton));

   scis_host_model u_host (.chip_select_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(soe));

   task automatic conclude();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic wcyc(input int n);
      repeat (n) @(negedge clk);
   endtask : wcyc

   task automatic rd_w(input logic [15:0] w, input int n = 16);
      u_host.xfer(w, n, rd);
      @(negedge clk);
      cmp(soe, 1'b0);
   endtask : rd_w

   function automatic logic [15:0] word(input logic [3:0] sel, input logic [11:0] st);
      return {sel, st[11:1], ~^st[11:1]};
   endfunction : word

   // Source index: 0 wake pin, 1 link wake, 2..7 clamps, supplies, temperature, 8..13 branches, 14 command.
   function automatic logic [11:0] imask(input int i);
      logic [11:0] m;
      m = '0;
      m[IRQ_WAKE] = i < 2 || i == 8 || i == 9;
      m[IRQ_BR1] = i == 8 || i == 10 || i == 12;
      m[IRQ_BR2] = i == 9 || i == 11 || i == 13;
      m[IRQ_CLAMP] = i == 2 || i == 3 || i == 12 || i == 13;
      m[IRQ_UV] = i == 4 || i == 5;
      m[IRQ_TEMP] = i == 6 || i == 7;
      m[IRQ_HC] = i == 14;
      return m;
   endfunction : imask

   task automatic ev(input int i);
      logic [11:0] m, c;
      m = imask(i);
      c = m & ~(12'h1 << IRQ_WAKE) & ~(12'h1 << IRQ_HC);
      src[i] = 1'b1;
      if (i == 1 || i == 14) begin
         @(negedge clk);
         src[i] = 1'b0;
      end
      wcyc(8);
      cmp(irq_n, 1'b0);
      rd_w(16'h1000);
      cmp(rd, word(SEL_IRQ, m));
      src[i] = 1'b0;
      rd_w(16'h1000);
      cmp(rd, word(SEL_IRQ, c));
      wcyc(8);
      cmp(irq_n, !(c != 0 && i != 8 && i != 9));
      rd_w(16'h1000);
      cmp(rd, word(SEL_IRQ, 12'h0));
      wcyc(8);
      cmp(irq_n, 1'b1);
      $display("event %0d done", i);
   endtask : ev

   initial begin
      logic [31:0] r;
      int k;
      wcyc(12);
      rstn = 1'b1;
      wcyc(8);
      cmp(irq_n, 1'b0);
      rd_w(16'h1000);
      cmp(rd, word(SEL_IRQ, IRQ_RST));
      rd_w(16'h1000);
      cmp(rd, word(SEL_IRQ, 12'h0));
      for (int i = 0; i < 15; i++) ev(i);
      repeat (20) ev($unsigned($random(seed)) % 15);
      for (int n = 15; n < 18; n += 2) begin
         rd_w(16'h1000, n);
         rd_w(16'h1000);
         cmp(rd, word(SEL_IRQ, 12'h1 << IRQ_SPI));
      end
      repeat (4) begin
         r = $random(seed);
         k = nval;
         rd_w({SEL_MODE, r[11:0]});
         cmp(mreq, r[11:0]);
         cmp(nval - k, 1);
      end
      rd_w(16'h1000);
      vio = 1'b1;
      k = nval;
      wcyc(2);
      cmp(blocked, 1'b1);
      rd_w({SEL_MODE, 12'h5a5});
      cmp(nval - k, 0);
      wcyc(TO_CYC);
      cmp(auton, 1'b1);
      vio = 1'b0;
      rd_w(16'h1000);
      cmp(rd, word(SEL_IRQ, 12'h1 << IRQ_UV));
      wcyc(8);
      cmp(irq_n, 1'b0);
      $display("serial, mode and supply tests done");
      rd_w(16'h2000);
      src[1:0] = 2'h3;
      coll = 1'b1;
      @(negedge clk);
      {coll, src[1]} = 2'h0;
      wcyc(6);
      rd_w(16'h2000);
      cmp(rd, word(SEL_GEN, 12'hc02));
      src[0] = 1'b0;
      rd_w(16'h2000);
      cmp(rd, word(SEL_GEN, 12'h0));
      repeat (8) begin
         r = $random(seed);
         guard = r[0];
         src[7:2] = r[6:1];
         wcyc(6);
         rd_w(16'h2000);
         cmp(rd, word(SEL_GEN, {2'h0, r[0], r[3], r[4], 1'b0, r[5], r[6], r[1], r[2], 2'h0}));
      end
      {guard, src[7:2]} = '0;
      latch = 1'b1;
      wcyc(6);
      rd_w(16'h2000);
      src[4] = 1'b1;
      wcyc(2);
      src[4] = 1'b0;
      wcyc(4);
      rd_w(16'h2000);
      cmp(rd, word(SEL_GEN, 12'h100));
      rd_w(16'h2000);
      cmp(rd, word(SEL_GEN, 12'h0));
      latch = 1'b0;
      src[0] = 1'b1;
      wcyc(6);
      mode = MODE_STANDBY;
      wcyc(2);
      mode = MODE_NORMAL;
      src[0] = 1'b0;
      rd_w(16'h2000);
      cmp(rd, word(SEL_GEN, 12'h0));
      $display("general status tests done");
      rstn = 1'b0;
      wcyc(12);
      rstn = 1'b1;
      wcyc(8);
      cmp(irq_n, 1'b0);
      rd_w(16'h1000);
      cmp(rd, word(SEL_IRQ, IRQ_RST));
      $display("second reset test done");
      conclude();
   end

   // A hung run counts as a failure rather than running on.
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      conclude();
   end
endmodule : scis_top_tb_top
`default_nettype wire
